// ### sase_map.vh
// constants for the set-all-ones / sleep execution unit
// assumes inclusion by sase_core.v, sase_wdt.v and by the checker and the bench
`ifndef SASE_MAP_VH
`define SASE_MAP_VH

// apb register byte offsets
`define SASE_OFF_INSTR 8'h00
`define SASE_OFF_BANK 8'h04
`define SASE_OFF_CORE_STAT 8'h08
`define SASE_OFF_WDT_CTRL 8'h0C
`define SASE_OFF_WDT_STAT 8'h10
`define SASE_OFF_MEM_ADDR 8'h14
`define SASE_OFF_MEM_DATA 8'h18
`define SASE_OFF_IRQ_STAT 8'h1C
`define SASE_OFF_IRQ_EN 8'h20
`define SASE_OFF_IRQ_CLR 8'h24

// instruction encodings
`define SASE_SET_ALL_ONES_INSTR_OPC 7'h34
`define SASE_SLEEP_WORD 16'h0003
`define SASE_SET_VALUE 8'hFF

// access bank split and upper bank
`define SASE_ACCESS_SPLIT 8'h80
`define SASE_ACCESS_HI_BANK 4'hF
`define SASE_ACCESS_LO_BANK 4'h0

// phases of an instruction cycle
`define SASE_Q1 2'h0
`define SASE_Q2 2'h1
`define SASE_Q3 2'h2
`define SASE_Q4 2'h3

// core status field positions
`define SASE_ST_PD 0
`define SASE_ST_TO 1
`define SASE_ST_ASLEEP 2
`define SASE_ST_BUSY 3
`define SASE_ST_PHASE_LO 4

// interrupt event bits
`define SASE_IRQ_W 5
`define SASE_EV_SET_ALL_ONES_INSTR 0
`define SASE_EV_SLEEP 1
`define SASE_EV_WDT_WAKE 2
`define SASE_EV_PIN_WAKE 3
`define SASE_EV_WDT_AWAKE 4

// reset values
`define SASE_RST_BANK 4'h0
`define SASE_RST_WDT_CTRL 4'h0
`define SASE_RST_PD 1'b1
`define SASE_RST_TO 1'b1
`define SASE_RST_INSTR 16'h0000

`endif

// ### sase_wdt.v
// watchdog timer with 8-bit count and 8-bit postscaler
// assumes a free-running clock; clear has priority over counting
`timescale 1ns/1ps
`include "sase_map.vh"

module sase_wdt (
    // clock and reset
    input wire clk_sys_in,
    input wire sys_rst_in,
    // control
    input wire enable_in,
    input wire clear_in,
    input wire [2:0] post_sel_in,
    // state
    output wire [7:0] count_out,
    output wire [7:0] post_out,
    output wire timeout_out
);

    reg [7:0] count_reg;
    reg [7:0] post_reg;
    reg timeout_reg;
    wire [7:0] post_limit;
    wire count_wrap;
    wire post_hit;

    assign post_limit = (8'h01 << post_sel_in) - 8'h01;
    assign count_wrap = enable_in && (count_reg == 8'hFF);
    assign post_hit = count_wrap && (post_reg >= post_limit);

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            count_reg <= 8'h00;
            post_reg <= 8'h00;
            timeout_reg <= 1'b0;
        end else if (clear_in) begin
            count_reg <= 8'h00;
            post_reg <= 8'h00;
            timeout_reg <= 1'b0;
        end else begin
            timeout_reg <= post_hit;
            if (enable_in) begin
                count_reg <= count_reg + 8'h01;
            end
            if (post_hit) begin
                post_reg <= 8'h00;
            end else if (count_wrap) begin
                post_reg <= post_reg + 8'h01;
            end
        end
    end

    assign count_out = count_reg;
    assign post_out = post_reg;
    assign timeout_out = timeout_reg;

endmodule

// ### sase_core.v
// execution unit for set-all-ones and sleep, with apb register access
// assumes apb clocked by clk_sys_in; wake pin is asynchronous
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "sase_map.vh"

module sase_core (
    // clock and reset
    input wire clk_sys_in,
    input wire sys_rst_in,
    // apb slave
    input wire [7:0] paddr_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    // wake pin
    input wire wake_pin_in,
    // core state
    output wire osc_run_out,
    output wire sleep_out,
    output wire power_down_flag_out,
    output wire time_out_flag_out,
    // interrupt
    output wire irq_out
);

    // data memory, 16 banks of 256
    reg [7:0] dmem [0:4095];

    reg [15:0] instr_reg;
    reg busy_reg;
    reg [1:0] phase_reg;
    reg op_set_all_ones_instr_reg;
    reg op_sleep_reg;
    reg [11:0] eff_addr_reg;
    reg [7:0] old_data_reg;
    reg [7:0] data_reg;
    reg asleep_reg;
    reg power_down_flag_reg;
    reg time_out_flag_reg;
    reg [3:0] bank_select_reg;
    reg [3:0] wdt_ctrl_reg;
    reg [11:0] mem_addr_reg;
    reg [`SASE_IRQ_W-1:0] irq_stat_reg;
    reg [`SASE_IRQ_W-1:0] irq_stat_next;
    reg [`SASE_IRQ_W-1:0] irq_en_reg;
    reg irq_reg;
    reg [31:0] prdata_reg;
    reg pslverr_reg;
    reg pready_reg;
    reg wake_meta_reg;
    reg wake_sync_reg;

    reg [31:0] rd_mux;
    reg rd_err;
    reg [11:0] eff_addr_next;
    reg [`SASE_IRQ_W-1:0] events;

    wire [7:0] wdt_count;
    wire [7:0] wdt_post;
    wire wdt_timeout;
    wire wdt_clear;
    wire access;
    wire stall;
    wire done;
    wire wr_done;
    wire issue;
    wire q4_set_all_ones_instr;
    wire q4_sleep;
    wire wake_wdt;
    wire wake_pin;
    wire apb_mem_wr;

    // transfers to the instruction and memory data registers wait while an instruction runs
    assign access = psel_in && penable_in;
    assign stall = busy_reg && ((paddr_in == `SASE_OFF_INSTR) || (paddr_in == `SASE_OFF_MEM_DATA));
    assign done = access && pready_reg;
    assign wr_done = done && pwrite_in;
    assign issue = wr_done && (paddr_in == `SASE_OFF_INSTR) && !asleep_reg;
    assign apb_mem_wr = wr_done && (paddr_in == `SASE_OFF_MEM_DATA);

    assign q4_set_all_ones_instr = busy_reg && (phase_reg == `SASE_Q4) && op_set_all_ones_instr_reg;
    assign q4_sleep = busy_reg && (phase_reg == `SASE_Q4) && op_sleep_reg;
    assign wdt_clear = q4_sleep;

    // watchdog keeps counting on clk_sys_in, the core clock, while the oscillator is stopped
    assign wake_wdt = asleep_reg && wdt_timeout;
    assign wake_pin = asleep_reg && wake_sync_reg && !wdt_timeout;

    sase_wdt u_wdt (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(wdt_ctrl_reg[0]),
        .clear_in(wdt_clear),
        .post_sel_in(wdt_ctrl_reg[3:1]),
        .count_out(wdt_count),
        .post_out(wdt_post),
        .timeout_out(wdt_timeout)
    );

    // wake pin synchroniser
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg <= wake_pin_in;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // effective address of the file operand
    always @* begin
        eff_addr_next = {bank_select_reg, instr_reg[7:0]};
        if (!instr_reg[8]) begin
            if (instr_reg[7:0] < `SASE_ACCESS_SPLIT) begin
                eff_addr_next = {`SASE_ACCESS_LO_BANK, instr_reg[7:0]};
            end else begin
                eff_addr_next = {`SASE_ACCESS_HI_BANK, instr_reg[7:0]};
            end
        end
    end

    // four-phase instruction sequencer
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            instr_reg <= `SASE_RST_INSTR;
            busy_reg <= 1'b0;
            phase_reg <= `SASE_Q1;
            op_set_all_ones_instr_reg <= 1'b0;
            op_sleep_reg <= 1'b0;
            eff_addr_reg <= 12'h000;
            old_data_reg <= 8'h00;
            data_reg <= 8'h00;
        end else if (issue) begin
            instr_reg <= pwdata_in[15:0];
            busy_reg <= 1'b1;
            phase_reg <= `SASE_Q1;
        end else if (busy_reg) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
                `SASE_Q1: begin
                    op_set_all_ones_instr_reg <= (instr_reg[15:9] == `SASE_SET_ALL_ONES_INSTR_OPC);
                    op_sleep_reg <= (instr_reg == `SASE_SLEEP_WORD);
                end
                `SASE_Q2: begin
                    eff_addr_reg <= eff_addr_next;
                    old_data_reg <= dmem[eff_addr_next];
                end
                `SASE_Q3: begin
                    data_reg <= old_data_reg | `SASE_SET_VALUE;
                end
                `SASE_Q4: begin
                    busy_reg <= 1'b0;
                    op_set_all_ones_instr_reg <= 1'b0;
                    op_sleep_reg <= 1'b0;
                end
                default: begin
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // data memory write port; core and apb never collide because of stall
    always @(posedge clk_sys_in) begin
        if (q4_set_all_ones_instr) begin
            dmem[eff_addr_reg] <= data_reg;
        end else if (apb_mem_wr) begin
            dmem[mem_addr_reg] <= pwdata_in[7:0];
        end
    end

    // sleep state and status flags
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            asleep_reg <= 1'b0;
            power_down_flag_reg <= `SASE_RST_PD;
            time_out_flag_reg <= `SASE_RST_TO;
        end else if (q4_sleep) begin
            asleep_reg <= 1'b1;
            power_down_flag_reg <= 1'b0;
            time_out_flag_reg <= 1'b1;
        end else if (wake_wdt) begin
            asleep_reg <= 1'b0;
            time_out_flag_reg <= 1'b0;
        end else if (wake_pin) begin
            asleep_reg <= 1'b0;
        end
    end

    // software registers
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            bank_select_reg <= `SASE_RST_BANK;
            wdt_ctrl_reg <= `SASE_RST_WDT_CTRL;
            mem_addr_reg <= 12'h000;
            irq_en_reg <= {`SASE_IRQ_W{1'b0}};
        end else if (wr_done) begin
            case (paddr_in)
                `SASE_OFF_BANK: bank_select_reg <= pwdata_in[3:0];
                `SASE_OFF_WDT_CTRL: wdt_ctrl_reg <= pwdata_in[3:0];
                `SASE_OFF_MEM_ADDR: mem_addr_reg <= pwdata_in[11:0];
                `SASE_OFF_IRQ_EN: irq_en_reg <= pwdata_in[`SASE_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky events; a new event wins over a clear in the same cycle
    always @* begin
        events = {`SASE_IRQ_W{1'b0}};
        events[`SASE_EV_SET_ALL_ONES_INSTR] = q4_set_all_ones_instr;
        events[`SASE_EV_SLEEP] = q4_sleep;
        events[`SASE_EV_WDT_WAKE] = wake_wdt;
        events[`SASE_EV_PIN_WAKE] = wake_pin;
        events[`SASE_EV_WDT_AWAKE] = wdt_timeout && !asleep_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_done && (paddr_in == `SASE_OFF_IRQ_CLR)) begin
            irq_stat_next = irq_stat_next & ~pwdata_in[`SASE_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | events;
    end

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            irq_stat_reg <= {`SASE_IRQ_W{1'b0}};
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_en_reg);
        end
    end

    // read data mux
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (paddr_in)
            `SASE_OFF_INSTR: rd_mux = {16'h0000, instr_reg};
            `SASE_OFF_BANK: rd_mux = {28'h0000000, bank_select_reg};
            `SASE_OFF_CORE_STAT: begin
                rd_mux[`SASE_ST_PD] = power_down_flag_reg;
                rd_mux[`SASE_ST_TO] = time_out_flag_reg;
                rd_mux[`SASE_ST_ASLEEP] = asleep_reg;
                rd_mux[`SASE_ST_BUSY] = busy_reg;
                rd_mux[`SASE_ST_PHASE_LO+1:`SASE_ST_PHASE_LO] = phase_reg;
            end
            `SASE_OFF_WDT_CTRL: rd_mux = {28'h0000000, wdt_ctrl_reg};
            `SASE_OFF_WDT_STAT: rd_mux = {16'h0000, wdt_post, wdt_count};
            `SASE_OFF_MEM_ADDR: rd_mux = {20'h00000, mem_addr_reg};
            `SASE_OFF_MEM_DATA: rd_mux = {24'h000000, dmem[mem_addr_reg]};
            `SASE_OFF_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_reg};
            `SASE_OFF_IRQ_EN: rd_mux = {27'h0000000, irq_en_reg};
            `SASE_OFF_IRQ_CLR: rd_mux = 32'h00000000;
            default: rd_err = 1'b1;
        endcase
    end

    // one wait state: data captured in the first free access cycle
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (done) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (access && !stall) begin
            pready_reg <= 1'b1;
            prdata_reg <= pwrite_in ? 32'h00000000 : rd_mux;
            pslverr_reg <= rd_err;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg && pready_reg;
    assign osc_run_out = !asleep_reg;
    assign sleep_out = asleep_reg;
    assign power_down_flag_out = power_down_flag_reg;
    assign time_out_flag_out = time_out_flag_reg;
    assign irq_out = irq_reg;

endmodule

// ### sase_core_chk.sv
// port assertions for sase_core
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`include "sase_map.vh"
module sase_core_chk (
    // clock and reset
    input wire clk_sys_in,
    input wire sys_rst_in,
    // apb
    input wire [7:0] paddr_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // core pins
    input wire wake_pin_in,
    input wire osc_run_out,
    input wire sleep_out,
    input wire power_down_flag_out,
    input wire time_out_flag_out,
    input wire irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_sleep_wr;
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == `SASE_OFF_INSTR &&
            pwdata_in[15:0] == `SASE_SLEEP_WORD && !sleep_out;
    endsequence
    sequence s_four_phases;
        !sleep_out [*4] ##1 sleep_out;
    endsequence
    property p_sleep_entry; s_sleep_wr |=> s_four_phases; endproperty
    property p_pd_clear; $rose(sleep_out) |-> !power_down_flag_out; endproperty
    property p_pd_cause; $fell(power_down_flag_out) |-> $rose(sleep_out); endproperty
    property p_to_set; $rose(sleep_out) |-> time_out_flag_out; endproperty
    property p_to_wake; $fell(time_out_flag_out) |-> $fell(sleep_out); endproperty
    property p_osc; osc_run_out != sleep_out; endproperty
    property p_pready; pready_out |=> !pready_out; endproperty
    property p_slverr; pslverr_out |-> pready_out && psel_in && penable_in; endproperty
    property p_answer; $rose(penable_in) && psel_in |-> ##[1:6] pready_out; endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing wrong");
    a_pd_clear: assert property (p_pd_clear) else $error("power-down flag not cleared");
    a_pd_cause: assert property (p_pd_cause) else $error("power-down flag fell outside sleep");
    a_to_set: assert property (p_to_set) else $error("time-out flag not set by sleep");
    a_to_wake: assert property (p_to_wake) else $error("time-out flag fell outside wake");
    a_osc: assert property (p_osc) else $error("oscillator runs while asleep");
    a_pready: assert property (p_pready) else $error("pready longer than one cycle");
    a_slverr: assert property (p_slverr) else $error("pslverr without pready");
    a_answer: assert property (p_answer) else $error("apb answer late");
endmodule
bind sase_core sase_core_chk u_chk (.clk_sys_in, .sys_rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .wake_pin_in, .osc_run_out, .sleep_out,
    .power_down_flag_out, .time_out_flag_out, .irq_out);

// ### sase_core_tb.sv
// self-checking bench for sase_core
// assumes the bench is apb master and drives the wake pin itself
`timescale 1ns/1ps
`include "sase_map.vh"
module sase_core_tb;
    reg clk_sys_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [7:0] paddr_in = 8'h00;
    reg psel_in = 1'b0;
    reg penable_in = 1'b0;
    reg pwrite_in = 1'b0;
    reg [31:0] pwdata_in = 32'h0;
    reg wake_pin_in = 1'b0;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, osc_run_out, sleep_out;
    wire power_down_flag_out, time_out_flag_out, irq_out;
    reg [31:0] rd;
    reg err;
    integer wn;
    integer errors = 0;
    integer samples_checked = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    sase_core u_dut (.clk_sys_in, .sys_rst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .wake_pin_in, .osc_run_out, .sleep_out,
        .power_down_flag_out, .time_out_flag_out, .irq_out);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys_in);
            psel_in <= 1'b1;
            paddr_in <= a;
            pwrite_in <= w;
            pwdata_in <= d;
            @(posedge clk_sys_in);
            penable_in <= 1'b1;
            n = 0;
            @(posedge clk_sys_in);
            while (pready_out !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk_sys_in);
            end
            chk({31'h0, pready_out}, 32'h1);
            rd = prdata_out;
            err = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task mem_wr(input [11:0] a, input [7:0] d);
        begin
            wr(`SASE_OFF_MEM_ADDR, {20'h0, a});
            wr(`SASE_OFF_MEM_DATA, {24'h0, d});
        end
    endtask
    task mem_chk(input [11:0] a, input [7:0] d);
        begin
            wr(`SASE_OFF_MEM_ADDR, {20'h0, a});
            apb(`SASE_OFF_MEM_DATA, 1'b0, 32'h0);
            chk(rd, {24'h0, d});
        end
    endtask
    task wait_sleep(input v, input integer lim);
        begin
            wn = 0;
            while (sleep_out !== v && wn < lim) begin
                wn = wn + 1;
                @(posedge clk_sys_in);
            end
            chk({31'h0, sleep_out}, {31'h0, v});
        end
    endtask
    task t_reset;
        begin
            chk({27'h0, osc_run_out, sleep_out, power_down_flag_out, time_out_flag_out, irq_out}, 32'h16);
            apb(`SASE_OFF_CORE_STAT, 1'b0, 32'h0);
            chk(rd, 32'h3);
            apb(`SASE_OFF_BANK, 1'b0, 32'h0);
            chk(rd, 32'h0);
            wr(`SASE_OFF_BANK, 32'h5);
        end
    endtask
    // bank 5 selected; hit must become FF, miss must keep 22
    task t_set_all_ones_instr(input a, input [7:0] f, input [11:0] hit, input [11:0] miss);
        begin
            mem_wr(hit, 8'h00);
            mem_wr(miss, 8'h22);
            wr(`SASE_OFF_INSTR, {16'h0, `SASE_SET_ALL_ONES_INSTR_OPC, a, f});
            mem_chk(hit, `SASE_SET_VALUE);
            mem_chk(miss, 8'h22);
        end
    endtask
    task t_irq;
        begin
            apb(`SASE_OFF_IRQ_STAT, 1'b0, 32'h0);
            chk(rd, 32'h1);
            wr(`SASE_OFF_IRQ_EN, 32'h1);
            repeat (2) @(posedge clk_sys_in);
            chk({31'h0, irq_out}, 32'h1);
            wr(`SASE_OFF_IRQ_EN, 32'h0);
            repeat (2) @(posedge clk_sys_in);
            chk({31'h0, irq_out}, 32'h0);
            wr(`SASE_OFF_IRQ_CLR, 32'h1F);
            apb(`SASE_OFF_IRQ_CLR, 1'b0, 32'h0);
            chk(rd, 32'h0);
            apb(`SASE_OFF_IRQ_STAT, 1'b0, 32'h0);
            chk(rd, 32'h0);
            apb(8'h3C, 1'b0, 32'h0);
            chk({31'h0, err}, 32'h1);
        end
    endtask
    task t_sleep_wdt;
        begin
            wr(`SASE_OFF_WDT_CTRL, 32'h1);
            repeat (40) @(posedge clk_sys_in);
            wr(`SASE_OFF_INSTR, {16'h0, `SASE_SLEEP_WORD});
            wait_sleep(1'b1, 10);
            chk({29'h0, osc_run_out, power_down_flag_out, time_out_flag_out}, 32'h1);
            apb(`SASE_OFF_WDT_STAT, 1'b0, 32'h0);
            chk({4'h0, rd[31:4]}, 32'h0);
            wait_sleep(1'b0, 400);
            chk({31'h0, wn > 240}, 32'h1);
            chk({30'h0, power_down_flag_out, time_out_flag_out}, 32'h0);
            wr(`SASE_OFF_WDT_CTRL, 32'h0);
        end
    endtask
    task t_pin_wake;
        begin
            mem_wr(12'h010, 8'h33);
            wr(`SASE_OFF_INSTR, {16'h0, `SASE_SLEEP_WORD});
            wait_sleep(1'b1, 10);
            chk({31'h0, time_out_flag_out}, 32'h1);
            wr(`SASE_OFF_INSTR, {16'h0, `SASE_SET_ALL_ONES_INSTR_OPC, 1'b0, 8'h10});
            @(posedge clk_sys_in);
            wake_pin_in <= 1'b1;
            wait_sleep(1'b0, 10);
            wake_pin_in <= 1'b0;
            chk({30'h0, power_down_flag_out, time_out_flag_out}, 32'h1);
            mem_chk(12'h010, 8'h33);
        end
    endtask
    task print_verdict;
        begin
            $display("errors=%0d samples_checked=%0d", errors, samples_checked);
            if (errors == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_set_all_ones_instr(1'b1, 8'h12, 12'h512, 12'h012);
        t_set_all_ones_instr(1'b1, 8'hFF, 12'h5FF, 12'hFFF);
        t_set_all_ones_instr(1'b0, 8'h7F, 12'h07F, 12'h57F);
        t_set_all_ones_instr(1'b0, 8'h80, 12'hF80, 12'h580);
        t_irq;
        t_sleep_wdt;
        t_pin_wake;
        print_verdict;
    end
    initial begin
        #2000000;
        errors = errors + 1;
        print_verdict;
    end
endmodule
